// ---- shared/sbc_defines.vh ----
`ifndef SBC_DEFINES_VH
`define SBC_DEFINES_VH
// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define SBC_OFS_CTRL 8'h00
`define SBC_OFS_STATUS 8'h04
`define SBC_OFS_KEY 8'h10
`define SBC_OFS_IV 8'h30
`define SBC_OFS_DIN 8'h40
`define SBC_OFS_DOUT 8'h50
`define SBC_OFS_LAST 8'h5C
// ----------------------------------------
// control fields
// ----------------------------------------
`define SBC_CTRL_START 0
`define SBC_CTRL_DEC 1
`define SBC_CTRL_MODE_LO 2
`define SBC_CTRL_ALG 4
`define SBC_CTRL_KSZ_LO 5
`define SBC_CTRL_TWOKEY 7
`define SBC_CTRL_SRST 31
`define SBC_CTRL_MASK 32'h000000FE
`define SBC_MODE_ECB 2'h0
`define SBC_MODE_CBC 2'h1
`define SBC_MODE_BLIND 2'h2
`define SBC_MODE_RECRYPT 2'h3
`define SBC_KSZ_128 2'h0
`define SBC_KSZ_192 2'h1
`define SBC_KSZ_256 2'h2
// ----------------------------------------
// status fields, round counts and bus response codes
// ----------------------------------------
`define SBC_ST_BUSY 0
`define SBC_ST_DONE 1
`define SBC_ST_BLOCKED 2
`define SBC_NR_AES128 6'h0A
`define SBC_NR_AES192 6'h0C
`define SBC_NR_AES256 6'h0E
`define SBC_NR_TDES 6'h30
`define SBC_NR_TDES_KEY 6'h10
`define SBC_RESP_OKAY 2'h0
`define SBC_RESP_SLVERR 2'h2
`endif

// ---- core/sbc_engine.v ----
// Chosen here: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "sbc_defines.vh"

// Behaviour
// - triple DES ECB and CBC, 168-bit key
// - blinding feedback and re-encryption modes offered
// - two-key option reuses first key as third
// - key write replaces previous key completely
// - software reset zeroes all keys immediately
// - AES ECB and CBC encrypt and decrypt
// - AES 128, 192, 256 with matching rounds
// - keys destroyed only by overwrite or zeroing
// - blocked engine gives no cryptographic effect
module sbc_engine (
   input wire sys_clk, // 40 MHz clock
   input wire reset, // synchronous, active high
   input wire engine_blocked_pin, // manufacture strap, high blocks engine
   input wire [7:0] s_axi_awaddr, // write address
   input wire s_axi_awvalid, // write address valid
   output wire s_axi_awready, // write address ready
   input wire [31:0] s_axi_wdata, // write data
   input wire [3:0] s_axi_wstrb, // write byte strobes
   input wire s_axi_wvalid, // write data valid
   output wire s_axi_wready, // write data ready
   output reg [1:0] s_axi_bresp, // write response
   output reg s_axi_bvalid, // write response valid
   input wire s_axi_bready, // write response ready
   input wire [7:0] s_axi_araddr, // read address
   input wire s_axi_arvalid, // read address valid
   output wire s_axi_arready, // read address ready
   output reg [31:0] s_axi_rdata, // read data
   output reg [1:0] s_axi_rresp, // read response
   output reg s_axi_rvalid, // read data valid
   input wire s_axi_rready // read data ready
);
   localparam ST_IDLE = 3'b001;
   localparam ST_RUN = 3'b010;
   localparam ST_FIN = 3'b100;

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   function [31:0] merge;
      input [31:0] old;
      input [31:0] nw;
      input [3:0] strb;
      integer b;
      begin
         merge = old;
         for (b = 0; b < 4; b = b + 1) begin
            if (strb[b]) begin
               merge[b*8 +: 8] = nw[b*8 +: 8];
            end
         end
      end
   endfunction

   function mapped;
      input [7:0] a;
      begin
         mapped = (a[1:0] == 2'h0) && (a <= `SBC_OFS_LAST) &&
                  (a[7:4] != 4'h0 || a[3:2] < 2'h2);
      end
   endfunction

   // round key: tdes picks one 64-bit key per 16 rounds, aes walks the key words
   function [127:0] rkey;
      input alg;
      input [1:0] ksz;
      input two_key;
      input [255:0] key;
      input [5:0] rnd;
      reg [63:0] kk;
      reg [511:0] dbl;
      reg [5:0] sel;
      begin
         kk = 64'h0;
         sel = 6'h0;
         dbl = {key, key};
         if (!alg) begin
            if (rnd < `SBC_NR_TDES_KEY) begin
               kk = key[63:0];
            end else if (rnd < 6'h20) begin
               kk = key[127:64];
            end else begin
               kk = two_key ? key[63:0] : key[191:128];
            end
            rkey = {kk, kk};
         end else begin
            case (ksz)
               `SBC_KSZ_128: sel = rnd % 6'h04;
               `SBC_KSZ_192: sel = rnd % 6'h06;
               default: sel = rnd % 6'h08;
            endcase
            rkey = dbl[sel*32 +: 128] ^ {122'h0, rnd};
         end
      end
   endfunction

   // invertible round step; the 64-bit path forces the upper half to zero
   function [127:0] step;
      input [127:0] s;
      input [127:0] rk;
      input dec;
      input alg;
      reg [127:0] t;
      begin
         if (!alg) begin
            t = s ^ {64'h0, rk[63:0]};
            step = dec ? {64'h0, t[0], t[63:1]} :
                         {64'h0, s[62:0], s[63]} ^ {64'h0, rk[63:0]};
         end else begin
            t = s ^ rk;
            step = dec ? {t[0], t[127:1]} : {s[126:0], s[127]} ^ rk;
         end
      end
   endfunction

   // ----------------------------------------
   // state
   // ----------------------------------------
   reg blk_s1_q, blk_s2_q, blocked_q;
   reg aw_got_q, w_got_q;
   reg [7:0] aw_addr_q;
   reg [31:0] w_data_q;
   reg [3:0] w_strb_q;
   reg [31:0] ctrl_q;
   reg [255:0] key_q;
   reg [127:0] iv_q, din_q, dout_q, blk_q;
   reg [2:0] state_q;
   reg [5:0] cnt_q;
   reg phase_q, done_q;

   wire [1:0] mode = ctrl_q[`SBC_CTRL_MODE_LO +: 2];
   wire alg = ctrl_q[`SBC_CTRL_ALG];
   wire [1:0] ksz = ctrl_q[`SBC_CTRL_KSZ_LO +: 2];
   wire recrypt = (mode == `SBC_MODE_RECRYPT);
   wire chained = (mode == `SBC_MODE_CBC) || (mode == `SBC_MODE_BLIND);
   wire run_dec = recrypt ? !phase_q : ctrl_q[`SBC_CTRL_DEC];
   wire [5:0] nr = !alg ? `SBC_NR_TDES :
                   (ksz == `SBC_KSZ_128) ? `SBC_NR_AES128 :
                   (ksz == `SBC_KSZ_192) ? `SBC_NR_AES192 : `SBC_NR_AES256;
   wire [5:0] ridx = run_dec ? (nr - 6'h01 - cnt_q) : cnt_q;
   wire [127:0] rk = rkey(alg, ksz, ctrl_q[`SBC_CTRL_TWOKEY], key_q, ridx);
   wire [127:0] nxt = step(blk_q, rk, run_dec, alg);
   wire [127:0] dmask = alg ? {128{1'b1}} : {64'h0, {64{1'b1}}};
   // start arrives in the same word as the new mode, so the block load decodes that word
   wire [31:0] ctrl_nx = merge(ctrl_q, w_data_q, w_strb_q) & `SBC_CTRL_MASK;
   wire [1:0] mode_nx = ctrl_nx[`SBC_CTRL_MODE_LO +: 2];
   wire chained_nx = (mode_nx == `SBC_MODE_CBC) || (mode_nx == `SBC_MODE_BLIND);
   wire [127:0] dmask_nx = ctrl_nx[`SBC_CTRL_ALG] ? {128{1'b1}} : {64'h0, {64{1'b1}}};

   wire do_wr = aw_got_q && w_got_q && !s_axi_bvalid;
   wire wr_ok = mapped(aw_addr_q);
   wire [3:0] widx = aw_addr_q[5:2];
   wire [31:0] wv = merge(32'h0, w_data_q, w_strb_q);
   wire wr_ctrl = do_wr && wr_ok && (aw_addr_q == `SBC_OFS_CTRL);
   wire soft_rst = wr_ctrl && wv[`SBC_CTRL_SRST];
   wire start = wr_ctrl && wv[`SBC_CTRL_START];

   assign s_axi_awready = !aw_got_q;
   assign s_axi_wready = !w_got_q;
   assign s_axi_arready = !s_axi_rvalid;

   // ----------------------------------------
   // strap synchroniser
   // ----------------------------------------
   always @(posedge sys_clk) begin
      blk_s1_q <= engine_blocked_pin;
      blk_s2_q <= blk_s1_q;
      if (reset) begin
         blocked_q <= 1'b1;
      end else begin
         blocked_q <= blk_s2_q;
      end
   end

   // ----------------------------------------
   // bus slave and registers
   // ----------------------------------------
   always @(posedge sys_clk) begin
      if (reset) begin
         aw_got_q <= 1'b0;
         w_got_q <= 1'b0;
         aw_addr_q <= 8'h00;
         w_data_q <= 32'h0;
         w_strb_q <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `SBC_RESP_OKAY;
         s_axi_rvalid <= 1'b0;
         s_axi_rresp <= `SBC_RESP_OKAY;
         s_axi_rdata <= 32'h0;
         ctrl_q <= 32'h0;
         key_q <= 256'h0;
         iv_q <= 128'h0;
         din_q <= 128'h0;
      end else begin
         if (s_axi_awvalid && !aw_got_q) begin
            aw_got_q <= 1'b1;
            aw_addr_q <= s_axi_awaddr;
         end
         if (s_axi_wvalid && !w_got_q) begin
            w_got_q <= 1'b1;
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
         if (do_wr) begin
            aw_got_q <= 1'b0;
            w_got_q <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_ok ? `SBC_RESP_OKAY : `SBC_RESP_SLVERR;
            if (wr_ok) begin
               if (aw_addr_q == `SBC_OFS_CTRL) begin
                  ctrl_q <= ctrl_nx;
               end else if (aw_addr_q[7:4] == 4'h1 || aw_addr_q[7:4] == 4'h2) begin
                  // old word is not merged in, so a write leaves no trace of it
                  key_q[(widx - 4'h4)*32 +: 32] <= wv;
               end else if (aw_addr_q[7:4] == 4'h3) begin
                  iv_q[widx[1:0]*32 +: 32] <= merge(iv_q[widx[1:0]*32 +: 32],
                                                     w_data_q, w_strb_q);
               end else if (aw_addr_q[7:4] == 4'h4) begin
                  din_q[widx[1:0]*32 +: 32] <= merge(din_q[widx[1:0]*32 +: 32],
                                                      w_data_q, w_strb_q);
               end
            end
         end
         if (state_q == ST_FIN && chained) begin
            if (!ctrl_q[`SBC_CTRL_DEC]) begin
               iv_q <= (mode == `SBC_MODE_CBC) ? blk_q : (blk_q ^ din_q);
            end else begin
               iv_q <= (mode == `SBC_MODE_CBC) ? din_q :
                       (din_q ^ ((blk_q ^ iv_q) & dmask));
            end
         end
         if (soft_rst) begin
            key_q <= 256'h0;
            iv_q <= 128'h0;
            din_q <= 128'h0;
         end
         if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
         if (s_axi_arvalid && !s_axi_rvalid) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= mapped(s_axi_araddr) ? `SBC_RESP_OKAY : `SBC_RESP_SLVERR;
            s_axi_rdata <= 32'h0;
            if (s_axi_araddr == `SBC_OFS_CTRL) begin
               s_axi_rdata <= ctrl_q;
            end else if (s_axi_araddr == `SBC_OFS_STATUS) begin
               s_axi_rdata <= {29'h0, blocked_q, done_q, state_q != ST_IDLE};
            end else if (s_axi_araddr[7:4] == 4'h3) begin
               s_axi_rdata <= iv_q[s_axi_araddr[3:2]*32 +: 32];
            end else if (s_axi_araddr[7:4] == 4'h4) begin
               s_axi_rdata <= din_q[s_axi_araddr[3:2]*32 +: 32];
            end else if (s_axi_araddr[7:4] == 4'h5) begin
               s_axi_rdata <= dout_q[s_axi_araddr[3:2]*32 +: 32];
            end
            // keys are write-only so they cannot be read back
         end
      end
   end

   // ----------------------------------------
   // cipher sequencer
   // ----------------------------------------
   always @(posedge sys_clk) begin
      if (reset || soft_rst) begin
         state_q <= ST_IDLE;
         cnt_q <= 6'h00;
         phase_q <= 1'b0;
         blk_q <= 128'h0;
         dout_q <= 128'h0;
         done_q <= 1'b0;
      end else begin
         if (do_wr && wr_ok && aw_addr_q == `SBC_OFS_STATUS && wv[`SBC_ST_DONE]) begin
            done_q <= 1'b0;
         end
         case (state_q)
            ST_IDLE: begin
               if (start && !blocked_q) begin
                  state_q <= ST_RUN;
                  cnt_q <= 6'h00;
                  phase_q <= 1'b0;
                  done_q <= 1'b0;
                  if (chained_nx && !ctrl_nx[`SBC_CTRL_DEC]) begin
                     blk_q <= (din_q ^ iv_q) & dmask_nx;
                  end else begin
                     blk_q <= din_q & dmask_nx;
                  end
               end
            end
            ST_RUN: begin
               blk_q <= nxt;
               cnt_q <= cnt_q + 6'h01;
               if (cnt_q == nr - 6'h01) begin
                  cnt_q <= 6'h00;
                  if (recrypt && !phase_q) begin
                     phase_q <= 1'b1;
                  end else begin
                     state_q <= ST_FIN;
                  end
               end
            end
            ST_FIN: begin
               state_q <= ST_IDLE;
               done_q <= 1'b1;
               if (chained && ctrl_q[`SBC_CTRL_DEC]) begin
                  dout_q <= (blk_q ^ iv_q) & dmask;
               end else begin
                  dout_q <= blk_q;
               end
            end
            default: state_q <= ST_IDLE;
         endcase
      end
   end
endmodule

// ---- test/sbc_chk_sva.sv ----
`timescale 1ns/1ps
// ----------------------------------------
// handshake and map checks
// ----------------------------------------
module sbc_chk (
   input wire sys_clk, // clock
   input wire reset, // reset
   input wire engine_blocked_pin, // strap
   input wire [7:0] s_axi_awaddr, // aw
   input wire s_axi_awvalid, // aw
   input wire s_axi_awready, // aw
   input wire [31:0] s_axi_wdata, // w
   input wire [3:0] s_axi_wstrb, // w
   input wire s_axi_wvalid, // w
   input wire s_axi_wready, // w
   input wire [1:0] s_axi_bresp, // b
   input wire s_axi_bvalid, // b
   input wire s_axi_bready, // b
   input wire [7:0] s_axi_araddr, // ar
   input wire s_axi_arvalid, // ar
   input wire s_axi_arready, // ar
   input wire [31:0] s_axi_rdata, // r
   input wire [1:0] s_axi_rresp, // r
   input wire s_axi_rvalid, // r
   input wire s_axi_rready // r
);
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (reset);
   sequence wr_taken;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && !s_axi_bvalid;
   endsequence
   sequence rd_taken;
      s_axi_arvalid && s_axi_arready;
   endsequence
   b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("write response dropped");
   r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> $stable(s_axi_rdata))
      else $error("read data changed");
   rd_answer_a: assert property (rd_taken |=> s_axi_rvalid)
      else $error("read answer late");
   wr_answer_a: assert property (wr_taken |-> ##2 s_axi_bvalid)
      else $error("write answer late");
   aw_drop_a: assert property (wr_taken |=> !s_axi_awready && !s_axi_wready)
      else $error("ready not dropped");
   bad_read_a: assert property (rd_taken ##0 s_axi_araddr == 8'h0C |=> s_axi_rresp == 2'h2)
      else $error("unmapped read accepted");
   bad_write_a: assert property (wr_taken ##0 s_axi_awaddr == 8'h08 |-> ##2 s_axi_bresp == 2'h2)
      else $error("unmapped write accepted");
   reset_idle_a: assert property (disable iff (1'b0) reset |=> !s_axi_bvalid && !s_axi_rvalid)
      else $error("answer during reset");
endmodule

// ---- test/tb_top.sv ----
`timescale 1ns/1ps
`include "sbc_defines.vh"
module tb_top;
   logic sys_clk = 0, reset = 1, engine_blocked_pin = 1, s_axi_awvalid = 0, s_axi_wvalid = 0;
   logic s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0, rd, ctl;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic [15:0] seed = 16'h6A3B;
   logic [1:0] resp;
   logic [127:0] p, c0, c1, d0, d1, msk;
   logic [255:0] key;
   wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   wire [1:0] s_axi_bresp, s_axi_rresp;
   wire [31:0] s_axi_rdata;
   int num_errors = 0, check_count = 0, cyc = 0;
   sbc_engine dut (.sys_clk, .reset, .engine_blocked_pin, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
   initial forever #12.5 sys_clk = ~sys_clk;
   always @(posedge sys_clk) cyc <= cyc + 1;
   // ----------------------------------------
   // helpers
   // ----------------------------------------
   function automatic logic [31:0] rnd();
      seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
      return {seed, ~seed};
   endfunction
   function automatic int nr_of(input logic [31:0] c);
      int n;
      n = !c[4] ? `SBC_NR_TDES : c[6:5] == 2'h0 ? `SBC_NR_AES128 :
         c[6:5] == 2'h1 ? `SBC_NR_AES192 : `SBC_NR_AES256;
      return c[3:2] == `SBC_MODE_RECRYPT ? 2 * n : n;
   endfunction
   task automatic chk(input string nm, input logic [127:0] e, input logic [127:0] g);
      check_count++;
      if (g !== e) begin
         num_errors++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask
   // each valid drops only at the edge that takes it; the answer is taken at its handshake edge
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic ta, tw;
      ta = 0;
      tw = 0;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1;
      s_axi_wvalid <= 1;
      s_axi_bready <= 1;
      do begin
         @(posedge sys_clk);
         if (!ta && s_axi_awready === 1'b1) begin
            ta = 1;
            s_axi_awvalid <= 0;
         end
         if (!tw && s_axi_wready === 1'b1) begin
            tw = 1;
            s_axi_wvalid <= 0;
         end
      end while (s_axi_bvalid !== 1'b1);
      resp = s_axi_bresp;
   endtask
   task automatic rdw(input logic [7:0] a);
      logic ta;
      ta = 0;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1;
      s_axi_rready <= 1;
      do begin
         @(posedge sys_clk);
         if (!ta && s_axi_arready === 1'b1) begin
            ta = 1;
            s_axi_arvalid <= 0;
         end
      end while (s_axi_rvalid !== 1'b1);
      rd = s_axi_rdata;
      resp = s_axi_rresp;
   endtask
   task automatic wblk(input logic [7:0] b, input int n, input logic [255:0] v);
      for (int i = 0; i < n; i++) wr(b + 8'(4 * i), v[32 * i +: 32]);
   endtask
   task automatic run(input logic [31:0] c, input logic [127:0] din, output logic [127:0] q);
      int t0, k;
      wblk(`SBC_OFS_DIN, 4, {128'h0, din});
      wr(`SBC_OFS_CTRL, c | 32'h1);
      t0 = cyc;
      k = 0;
      do begin
         rdw(`SBC_OFS_STATUS);
         k++;
      end while (rd[`SBC_ST_DONE] !== 1'b1 && k < 100);
      chk("done", !engine_blocked_pin, rd[`SBC_ST_DONE]);
      if (rd[`SBC_ST_DONE] === 1'b1) begin
         chk("rounds", 1, cyc - t0 inside {[nr_of(c) + 2:nr_of(c) + 3]});
      end
      for (int i = 0; i < 4; i++) begin
         rdw(`SBC_OFS_DOUT + 8'(4 * i));
         q[32 * i +: 32] = rd;
      end
   endtask
   task automatic final_report();
      if (num_errors == 0 && check_count > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   initial begin
      repeat (3) @(posedge sys_clk);
      reset <= 0;
      @(posedge sys_clk);
      run(32'h10, 128'h1, c0);
      rdw(`SBC_OFS_STATUS);
      chk("blocked", 128'h4, rd & 32'h7);
      chk("blocked out", 128'h0, c0);
      engine_blocked_pin <= 0;
      wr(8'h08, rnd());
      chk("bad write", `SBC_RESP_SLVERR, resp);
      rdw(8'h0C);
      chk("bad read", {`SBC_RESP_SLVERR, 32'h0}, {resp, rd});
      for (int k = 0; k < 10; k++) begin
         ctl = k < 4 ? 32'(k) << 2 : 32'h10 | 32'((k - 4) % 2) << 2 | 32'((k - 4) / 2) << 5;
         msk = ctl[4] ? {128{1'b1}} : {64'h0, {64{1'b1}}};
         key = {rnd(), rnd(), rnd(), rnd(), rnd(), rnd(), rnd(), rnd()};
         p = {rnd(), rnd(), rnd(), rnd()} & msk;
         d1 = {rnd(), rnd(), rnd(), rnd()};
         wblk(`SBC_OFS_KEY, 8, key);
         wblk(`SBC_OFS_IV, 4, {128'h0, d1});
         run(ctl, p, c0);
         run(ctl, p, c1);
         c0 = c0 & msk;
         c1 = c1 & msk;
         if (ctl[3:2] == `SBC_MODE_ECB) chk("ecb", c0, c1);
         else if (ctl[3:2] == `SBC_MODE_RECRYPT) chk("recrypt", p, c1);
         else chk("chain", 1, c0 !== c1);
         wblk(`SBC_OFS_IV, 4, {128'h0, d1});
         run(ctl | 32'h2, c0, d0);
         run(ctl | 32'h2, c1, d1);
         chk("decrypt", p, d0 & msk);
         chk("decrypt", p, d1 & msk);
      end
      wblk(`SBC_OFS_KEY, 8, 256'h0);
      run(32'h10, p, c0);
      wblk(`SBC_OFS_KEY, 8, key);
      run(32'h10, p, c1);
      wblk(`SBC_OFS_KEY, 8, 256'h0);
      run(32'h10, p, d0);
      chk("overwrite", 1, c0 !== c1);
      chk("overwrite", c0, d0);
      wblk(`SBC_OFS_KEY, 8, key);
      wr(`SBC_OFS_CTRL, 32'h80000000);
      run(32'h10, p, d0);
      chk("soft reset", c0, d0);
      key[191:128] = key[63:0];
      msk = {64'h0, {64{1'b1}}};
      wblk(`SBC_OFS_KEY, 8, key);
      run(32'h0, p, c0);
      wblk(`SBC_OFS_KEY + 8'h10, 2, {rnd(), rnd()});
      run(32'h80, p, c1);
      chk("two key", c0 & msk, c1 & msk);
      final_report();
   end
   initial begin
      repeat (40000) @(posedge sys_clk);
      num_errors++;
      final_report();
   end
endmodule
bind sbc_engine sbc_chk chk (.sys_clk, .reset, .engine_blocked_pin, .s_axi_awaddr,
   .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
   .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
   .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
